// ===== pkg/cwp_pkg.sv
// ---------------------------------------------------------------
// Constants for the configuration word and protection block
// ---------------------------------------------------------------
package cwp_pkg;

  // Register indices; byte address on APB is four times the index
  localparam logic [15:0] IDX_USER_ID0 = 16'h8000;
  localparam logic [15:0] IDX_USER_ID3 = 16'h8003;
  localparam logic [15:0] IDX_DEV_WORD = 16'h8006;
  localparam logic [15:0] IDX_CFG1 = 16'h8007;
  localparam logic [15:0] IDX_CFG2 = 16'h8008;
  localparam logic [15:0] IDX_WDOG_CTRL = 16'h8010;
  localparam logic [15:0] IDX_BOR_CTRL = 16'h8011;
  localparam logic [15:0] IDX_STATUS = 16'h8012;

  // Program memory size in words
  localparam logic [15:0] PMEM_WORDS = 16'h0400;

  // Erased word and implemented-bit masks of both words
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [13:0] CFG1_IMPL_MASK = 14'h0EFB;
  localparam logic [13:0] CFG2_IMPL_MASK = 14'h2E03;

  // Field positions in config word one
  localparam int CFG1_CLKOUT_BIT = 11;
  localparam int CFG1_BOR_EN_LSB = 9;
  localparam int CFG1_CODE_PROT_BIT = 7;
  localparam int CFG1_WDOG_LSB = 3;
  localparam int CFG1_OSC_LSB = 0;
  localparam logic [13:0] CFG1_CODE_PROT_MASK = 14'h0080;

  // Field positions in config word two
  localparam int CFG2_BOR_LEVEL_BIT = 10;
  localparam int CFG2_STACK_RST_BIT = 9;
  localparam int CFG2_SELF_WP_LSB = 0;

  // Status register bit positions
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_UNF_BIT = 1;
  localparam int STAT_OSC_LSB = 2;
  localparam int STAT_WDOG_BIT = 4;
  localparam int STAT_BOR_BIT = 5;
  localparam int STAT_LOADED_BIT = 6;

  // Upper clock limits of each oscillator mode, in kHz
  localparam logic [14:0] EXT_LOW_MAX_KHZ = 15'h01F4;
  localparam logic [14:0] EXT_MED_MAX_KHZ = 15'h0FA0;
  localparam logic [14:0] EXT_HIGH_MAX_KHZ = 15'h4E20;
  localparam logic [14:0] INT_OSC_MAX_KHZ = 15'h3E80;

  // Self-write protection bounds (first unprotected word)
  localparam logic [10:0] WP_BOUND_NONE = 11'h000;
  localparam logic [10:0] WP_BOUND_LOW = 11'h100;
  localparam logic [10:0] WP_BOUND_HALF = 11'h200;
  localparam logic [10:0] WP_BOUND_ALL = 11'h400;

  // Oscillator select field codes
  typedef enum logic [1:0] {
    OSC_INTERNAL = 2'b00,
    OSC_EXT_LOW = 2'b01,
    OSC_EXT_MED = 2'b10,
    OSC_EXT_HIGH = 2'b11
  } cwp_osc_t;

  // Watchdog and brown-out enable field codes
  typedef enum logic [1:0] {
    EN_OFF = 2'b00,
    EN_SOFT = 2'b01,
    EN_RUN_ONLY = 2'b10,
    EN_ALWAYS = 2'b11
  } cwp_en_t;

  // External programmer handshake states
  typedef enum logic [1:0] {
    EXT_IDLE = 2'b01,
    EXT_HOLD = 2'b10
  } cwp_ext_t;

endpackage

// ===== hdl/cwp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ---------------------------------------------------------------
module cwp_sync
  import cwp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin level in, filtered level out
  input wire logic d,
  output logic q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic q_q;

  // Shift chain; only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Output follows once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      q_q <= s3_q;
    end
  end

  assign q = q_q;

endmodule
`default_nettype wire

// ===== hdl/cwp_top.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Config words at 8007h and 8008h, 14 bits
// - Unimplemented bits always read as one
// - Code protect zero blocks external program memory access, reads zero
// - Code protect cleared only by bulk erase or by por_n
// - CPU reads ignore all protection settings
// - Watchdog field: always, run-only, software, off
// - Oscillator field picks one of four modes
// - Oscillator mode applied at power-up
// - External bands: 0.5, 4, 20 MHz limits
// - Brown-out level: zero high, one low
// - Stack reset enable resets on stack fault
// - Write-protect field sets protected word range
// - Self-writes into protected range are blocked
// - Four user ID words are read-write
// - ID word holds part and revision codes
// - ID word is read-only, readable externally
// - Oscillator codes: 11 high, 10 med, 01 low
// - Stack wraps when reset disabled; flags still set
module cwp_top
  import cwp_pkg::*;
#(
  parameter logic [8:0] PART_CODE = 9'h0A5, // Arbitrary value
  parameter logic [4:0] REV_CODE = 5'h01 // Arbitrary value
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power-on reset of the nonvolatile cells
  input wire logic por_n,
  // CPU side
  input wire logic sleep_mode,
  input wire logic [9:0] cpu_rd_addr,
  output logic [13:0] cpu_rd_data,
  input wire logic self_wr_req,
  input wire logic [9:0] self_wr_addr,
  input wire logic [13:0] self_wr_data,
  output logic self_wr_done,
  output logic self_wr_blocked,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  output logic stack_fault_reset,
  output logic stack_wrap_mode,
  // External programmer pins
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic ext_erase,
  input wire logic [15:0] ext_addr,
  input wire logic [13:0] ext_wdata,
  output logic ext_ack,
  output logic [13:0] ext_rdata,
  // Decoded settings
  output logic ext_clock_low_power,
  output logic ext_clock_medium_power,
  output logic ext_clock_high_power,
  output logic internal_osc_mode,
  output logic [14:0] max_clock_khz,
  output logic watchdog_run,
  output logic brownout_run,
  output logic brownout_high_trip,
  output logic clock_out_enable
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Unimplemented bits of a word read as one
  function automatic logic [13:0] cfg_view(input logic [13:0] w,
                                           input logic [13:0] m);
    cfg_view = w | ~m;
  endfunction

  // First unprotected word for a write-protect code
  function automatic logic [10:0] wp_bound(input logic [1:0] f);
    logic [10:0] b;
    b = WP_BOUND_ALL;
    unique case (f)
      2'b11: b = WP_BOUND_NONE;
      2'b10: b = WP_BOUND_LOW;
      2'b01: b = WP_BOUND_HALF;
      2'b00: b = WP_BOUND_ALL;
    endcase
    wp_bound = b;
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [13:0] pmem_q [0:1023];
  logic [1023:0] pvalid_q;
  logic [13:0] cfg1_q;
  logic [13:0] cfg2_q;
  logic [13:0] uid_q [0:3];
  logic [13:0] act_cfg1_q;
  logic [13:0] act_cfg2_q;
  logic loaded_q;
  logic [13:0] dev_word;
  logic cp_n;

  assign dev_word = {PART_CODE, REV_CODE};
  assign cp_n = cfg1_q[CFG1_CODE_PROT_BIT];

  // ---------------------------------------------------------------
  // External programmer port
  // ---------------------------------------------------------------
  logic ext_req_s;
  cwp_ext_t ext_st_q;
  logic ext_go;
  logic ext_ack_q;
  logic [13:0] ext_rdata_q;
  logic [13:0] ext_rd_d;
  logic ext_pm;
  logic ext_pm_we;
  logic ext_uid_we;

  cwp_sync u_req_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(ext_req),
    .q(ext_req_s)
  );

  // Four-phase handshake on the synchronised request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_st_q <= EXT_IDLE;
    end else begin
      unique case (ext_st_q)
        EXT_IDLE: if (ext_req_s) ext_st_q <= EXT_HOLD;
        EXT_HOLD: if (!ext_req_s) ext_st_q <= EXT_IDLE;
        default: ext_st_q <= EXT_IDLE;
      endcase
    end
  end

  assign ext_go = (ext_st_q == EXT_IDLE) && ext_req_s;
  assign ext_pm = ext_addr < PMEM_WORDS;
  assign ext_pm_we = ext_go && ext_we && !ext_erase && ext_pm && cp_n;
  assign ext_uid_we = ext_go && ext_we && !ext_erase &&
                      (ext_addr[15:2] == IDX_USER_ID0[15:2]);

  // External read data
  always_comb begin
    ext_rd_d = '0;
    if (ext_pm) begin
      if (cp_n && pvalid_q[ext_addr[9:0]]) begin
        ext_rd_d = pmem_q[ext_addr[9:0]];
      end else if (cp_n) begin
        ext_rd_d = ERASED_WORD;
      end
    end else if (ext_addr[15:2] == IDX_USER_ID0[15:2]) begin
      ext_rd_d = uid_q[ext_addr[1:0]];
    end else if (ext_addr == IDX_DEV_WORD) begin
      ext_rd_d = dev_word;
    end else if (ext_addr == IDX_CFG1) begin
      ext_rd_d = cfg_view(cfg1_q, CFG1_IMPL_MASK);
    end else if (ext_addr == IDX_CFG2) begin
      ext_rd_d = cfg_view(cfg2_q, CFG2_IMPL_MASK);
    end
  end

  // Acknowledge and read data toward the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ack_q <= 1'b0;
      ext_rdata_q <= '0;
    end else if (ext_go) begin
      ext_ack_q <= 1'b1;
      ext_rdata_q <= (ext_we || ext_erase) ? 14'h0000 : ext_rd_d;
    end else if (!ext_req_s) begin
      ext_ack_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic [15:0] apb_idx;
  logic apb_setup;
  logic apb_commit;
  logic apb_hit;
  logic [31:0] apb_rd_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic soft_wdog_q;
  logic soft_bor_q;
  logic ovf_q;
  logic unf_q;
  logic watchdog_run_q;
  logic brownout_run_q;
  logic apb_uid_we;

  assign apb_idx = paddr[17:2];
  assign apb_setup = psel && !penable;
  assign apb_commit = psel && penable && pready_q && pwrite && apb_hit;
  assign apb_uid_we = apb_commit &&
                      (apb_idx[15:2] == IDX_USER_ID0[15:2]);

  // Address decode and read mux
  always_comb begin
    apb_rd_d = '0;
    apb_hit = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      apb_hit = 1'b0;
    end else if (apb_idx[15:2] == IDX_USER_ID0[15:2]) begin
      apb_rd_d[13:0] = uid_q[apb_idx[1:0]];
    end else if (apb_idx == IDX_DEV_WORD) begin
      apb_rd_d[13:0] = dev_word;
    end else if (apb_idx == IDX_CFG1) begin
      apb_rd_d[13:0] = cfg_view(cfg1_q, CFG1_IMPL_MASK);
    end else if (apb_idx == IDX_CFG2) begin
      apb_rd_d[13:0] = cfg_view(cfg2_q, CFG2_IMPL_MASK);
    end else if (apb_idx == IDX_WDOG_CTRL) begin
      apb_rd_d[0] = soft_wdog_q;
    end else if (apb_idx == IDX_BOR_CTRL) begin
      apb_rd_d[0] = soft_bor_q;
    end else if (apb_idx == IDX_STATUS) begin
      apb_rd_d[STAT_OVF_BIT] = ovf_q;
      apb_rd_d[STAT_UNF_BIT] = unf_q;
      apb_rd_d[STAT_OSC_LSB +: 2] = act_cfg1_q[CFG1_OSC_LSB +: 2];
      apb_rd_d[STAT_WDOG_BIT] = watchdog_run_q;
      apb_rd_d[STAT_BOR_BIT] = brownout_run_q;
      apb_rd_d[STAT_LOADED_BIT] = loaded_q;
    end else begin
      apb_hit = 1'b0;
    end
  end

  // Answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !apb_hit;
      prdata_q <= (apb_setup && !pwrite) ? apb_rd_d : 32'h0000_0000;
    end
  end

  // Software enable bits for watchdog and brown-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_wdog_q <= 1'b0;
      soft_bor_q <= 1'b0;
    end else if (apb_commit && apb_idx == IDX_WDOG_CTRL) begin
      soft_wdog_q <= pwdata[0];
    end else if (apb_commit && apb_idx == IDX_BOR_CTRL) begin
      soft_bor_q <= pwdata[0];
    end
  end

  // Sticky stack flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      ovf_q <= stack_overflow || (ovf_q && !(apb_commit &&
               apb_idx == IDX_STATUS && pwdata[STAT_OVF_BIT]));
      unf_q <= stack_underflow || (unf_q && !(apb_commit &&
               apb_idx == IDX_STATUS && pwdata[STAT_UNF_BIT]));
    end
  end

  // ---------------------------------------------------------------
  // Nonvolatile cells
  // ---------------------------------------------------------------
  logic sw_hit;
  logic sw_ok;

  assign sw_hit = {1'b0, self_wr_addr} < wp_bound(act_cfg2_q[1:0]);
  assign sw_ok = self_wr_req && !sw_hit && !ext_pm_we;

  // Config words, user IDs and erased map
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cfg1_q <= ERASED_WORD;
      cfg2_q <= ERASED_WORD;
      pvalid_q <= '0;
      for (int i = 0; i < 4; i++) begin
        uid_q[i] <= ERASED_WORD;
      end
    end else if (ext_go && ext_erase) begin
      cfg1_q <= ERASED_WORD;
      cfg2_q <= ERASED_WORD;
      pvalid_q <= '0;
      for (int i = 0; i < 4; i++) begin
        uid_q[i] <= ERASED_WORD;
      end
    end else begin
      if (ext_go && ext_we && ext_addr == IDX_CFG1) begin
        cfg1_q <= ext_wdata & (cfg1_q | ~CFG1_CODE_PROT_MASK);
      end
      if (ext_go && ext_we && ext_addr == IDX_CFG2) begin
        cfg2_q <= ext_wdata;
      end
      if (ext_uid_we) begin
        uid_q[ext_addr[1:0]] <= ext_wdata;
      end else if (apb_uid_we) begin
        uid_q[apb_idx[1:0]] <= pwdata[13:0];
      end
      if (ext_pm_we) begin
        pvalid_q[ext_addr[9:0]] <= 1'b1;
      end else if (sw_ok) begin
        pvalid_q[self_wr_addr] <= 1'b1;
      end
    end
  end

  // Program memory array
  always_ff @(posedge pclk) begin
    if (ext_pm_we) begin
      pmem_q[ext_addr[9:0]] <= ext_wdata;
    end else if (sw_ok) begin
      pmem_q[self_wr_addr] <= self_wr_data;
    end
  end

  // ---------------------------------------------------------------
  // CPU access
  // ---------------------------------------------------------------
  logic [13:0] cpu_rd_q;
  logic sw_done_q;
  logic sw_blocked_q;

  // CPU reads see memory whatever the protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rd_q <= ERASED_WORD;
    end else begin
      cpu_rd_q <= pvalid_q[cpu_rd_addr] ? pmem_q[cpu_rd_addr]
                                        : ERASED_WORD;
    end
  end

  // Self-write outcome
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_done_q <= 1'b0;
      sw_blocked_q <= 1'b0;
    end else begin
      sw_done_q <= sw_ok;
      sw_blocked_q <= self_wr_req && !sw_ok;
    end
  end

  // ---------------------------------------------------------------
  // Settings captured after reset and decoded
  // ---------------------------------------------------------------
  logic osc_low_q;
  logic osc_med_q;
  logic osc_high_q;
  logic osc_int_q;
  logic [14:0] max_khz_q;
  logic bor_high_q;
  logic stack_rst_q;
  logic wrap_q;
  logic clkout_q;
  cwp_osc_t act_osc;
  cwp_en_t act_wdog;
  cwp_en_t act_bor;
  logic stack_rst_en;

  assign act_osc = cwp_osc_t'(act_cfg1_q[CFG1_OSC_LSB +: 2]);
  assign act_wdog = cwp_en_t'(act_cfg1_q[CFG1_WDOG_LSB +: 2]);
  assign act_bor = cwp_en_t'(act_cfg1_q[CFG1_BOR_EN_LSB +: 2]);
  assign stack_rst_en = act_cfg2_q[CFG2_STACK_RST_BIT];

  // Capture the stored words once after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      act_cfg1_q <= ERASED_WORD;
      act_cfg2_q <= ERASED_WORD;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      act_cfg1_q <= cfg1_q;
      act_cfg2_q <= cfg2_q;
    end
  end

  // Oscillator mode and its clock limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_low_q <= 1'b0;
      osc_med_q <= 1'b0;
      osc_high_q <= 1'b1;
      osc_int_q <= 1'b0;
      max_khz_q <= EXT_HIGH_MAX_KHZ;
    end else begin
      osc_low_q <= act_osc == OSC_EXT_LOW;
      osc_med_q <= act_osc == OSC_EXT_MED;
      osc_high_q <= act_osc == OSC_EXT_HIGH;
      osc_int_q <= act_osc == OSC_INTERNAL;
      unique case (act_osc)
        OSC_EXT_LOW: max_khz_q <= EXT_LOW_MAX_KHZ;
        OSC_EXT_MED: max_khz_q <= EXT_MED_MAX_KHZ;
        OSC_EXT_HIGH: max_khz_q <= EXT_HIGH_MAX_KHZ;
        OSC_INTERNAL: max_khz_q <= INT_OSC_MAX_KHZ;
      endcase
    end
  end

  // Watchdog and brown-out run decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_run_q <= 1'b0;
      brownout_run_q <= 1'b0;
    end else begin
      unique case (act_wdog)
        EN_ALWAYS: watchdog_run_q <= 1'b1;
        EN_RUN_ONLY: watchdog_run_q <= !sleep_mode;
        EN_SOFT: watchdog_run_q <= soft_wdog_q;
        EN_OFF: watchdog_run_q <= 1'b0;
      endcase
      unique case (act_bor)
        EN_ALWAYS: brownout_run_q <= 1'b1;
        EN_RUN_ONLY: brownout_run_q <= !sleep_mode;
        EN_SOFT: brownout_run_q <= soft_bor_q;
        EN_OFF: brownout_run_q <= 1'b0;
      endcase
    end
  end

  // Brown-out level, stack behaviour, clock out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bor_high_q <= 1'b0;
      stack_rst_q <= 1'b0;
      wrap_q <= 1'b0;
      clkout_q <= 1'b0;
    end else begin
      bor_high_q <= !act_cfg2_q[CFG2_BOR_LEVEL_BIT];
      stack_rst_q <= stack_rst_en &&
                     (stack_overflow || stack_underflow);
      wrap_q <= !stack_rst_en;
      clkout_q <= !act_cfg1_q[CFG1_CLKOUT_BIT];
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_rd_data = cpu_rd_q;
  assign self_wr_done = sw_done_q;
  assign self_wr_blocked = sw_blocked_q;
  assign stack_fault_reset = stack_rst_q;
  assign stack_wrap_mode = wrap_q;
  assign ext_ack = ext_ack_q;
  assign ext_rdata = ext_rdata_q;
  assign ext_clock_low_power = osc_low_q;
  assign ext_clock_medium_power = osc_med_q;
  assign ext_clock_high_power = osc_high_q;
  assign internal_osc_mode = osc_int_q;
  assign max_clock_khz = max_khz_q;
  assign watchdog_run = watchdog_run_q;
  assign brownout_run = brownout_run_q;
  assign brownout_high_trip = bor_high_q;
  assign clock_out_enable = clkout_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ext_start;
    ext_go;
  endsequence

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  chk_apb_one_wait: assert property (
    s_apb_setup |=> pready ##1 !pready)
    else $error("APB answer not exactly one cycle");
  chk_cfg_unimpl_ones: assert property (
    s_apb_setup ##1 (!pwrite && apb_idx == IDX_CFG1)
      |-> (prdata[13:0] & ~CFG1_IMPL_MASK) == ~CFG1_IMPL_MASK)
    else $error("Unimplemented config bits not one");
  chk_ext_prot_zero: assert property (
    s_ext_start and (!ext_we && !ext_erase && ext_pm && !cp_n)
      |=> ext_rdata == 14'h0000)
    else $error("Protected external read not zero");
  chk_cp_sticky: assert property (
    (!cp_n && !(ext_go && ext_erase) && por_n) |=> !cp_n)
    else $error("Code protect cleared without erase");
  chk_cpu_erased: assert property (
    !pvalid_q[cpu_rd_addr] |=> cpu_rd_data == ERASED_WORD)
    else $error("CPU read of erased word wrong");
  chk_wdog_decode: assert property (
    (loaded_q && act_wdog == EN_OFF) |=> !watchdog_run ##0
      (act_wdog != EN_ALWAYS || $past(act_wdog) != EN_ALWAYS ||
       watchdog_run))
    else $error("Watchdog decode wrong");
  chk_osc_high_band: assert property (
    act_osc == OSC_EXT_HIGH
      |=> ext_clock_high_power && max_clock_khz == EXT_HIGH_MAX_KHZ)
    else $error("High power band not applied");
  chk_load_power_up: assert property (
    $rose(loaded_q) |-> act_cfg1_q == $past(cfg1_q))
    else $error("Settings not captured after reset");
  chk_bor_level: assert property (
    !act_cfg2_q[CFG2_BOR_LEVEL_BIT] |=> brownout_high_trip)
    else $error("Brown-out trip level wrong");
  chk_stack_reset: assert property (
    (stack_overflow || stack_underflow)
      |=> stack_fault_reset == $past(stack_rst_en))
    else $error("Stack fault reset wrong");
  chk_stack_flag: assert property (
    stack_overflow |=> ovf_q)
    else $error("Overflow flag lost");
  chk_self_wr_block: assert property (
    (self_wr_req && sw_hit) |=> self_wr_blocked && !self_wr_done)
    else $error("Protected self-write not blocked");
  chk_ext_dev_word: assert property (
    s_ext_start and (!ext_we && !ext_erase && ext_addr == IDX_DEV_WORD)
      |=> ext_ack && ext_rdata == dev_word)
    else $error("Identification read wrong");

endmodule
`default_nettype wire

// ===== sim/cwp_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
// Programmer model: four-phase request and acknowledge
module cwp_prog_model (
  // Clock and answer from the device
  input wire logic clk,
  input wire logic ext_ack,
  input wire logic [13:0] ext_rdata,
  // Request pins
  output logic ext_req,
  output logic ext_we,
  output logic ext_erase,
  output logic [15:0] ext_addr,
  output logic [13:0] ext_wdata
);
  logic [13:0] rd;
  // Idle pins at time zero
  initial begin
    ext_req = 1'b0;
    ext_we = 1'b0;
    ext_erase = 1'b0;
    ext_addr = 16'h0000;
    ext_wdata = 14'h0000;
  end
  // One word per transfer, ID word reads included
  task xfer(input logic w, input logic e, input logic [15:0] a,
            input logic [13:0] d);
    int k;
    @(posedge clk);
    ext_req <= 1'b1;
    ext_we <= w;
    ext_erase <= e;
    ext_addr <= a;
    ext_wdata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ext_ack !== 1'b1 && k < 30);
    if (k >= 30) config_word_protection_tb.hang();
    rd = ext_rdata;
    ext_req <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (ext_ack !== 1'b0 && k < 60);
    // Released lines stop showing the old value
    ext_addr <= ~a;
    ext_wdata <= ~d;
    if (k >= 60) config_word_protection_tb.hang();
  endtask
endmodule
`default_nettype wire

// ===== sim/config_word_protection_tb.sv
`timescale 1ns/1ns
`default_nettype none
module config_word_protection_tb;
  import cwp_pkg::*;
  typedef struct {logic w; logic [15:0] i; logic [31:0] d, x; logic e;} cwp_row_t;
  localparam logic [8:0] PART = 9'h0A5; // Arbitrary value
  localparam logic [31:0] IDW = {18'h0, PART, 5'h01};
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, sleep_mode = 0, self_wr_req = 0;
  logic stack_overflow = 0, stack_underflow = 0;
  logic [9:0] cpu_rd_addr = 0, self_wr_addr = 0;
  logic [13:0] cpu_rd_data, ext_rdata, ext_wdata, self_wr_data = 14'h0AAA;
  logic self_wr_done, self_wr_blocked, stack_fault_reset, stack_wrap_mode;
  logic ext_req, ext_we, ext_erase, ext_ack, clock_out_enable;
  logic [15:0] ext_addr;
  logic ext_clock_low_power, ext_clock_medium_power, ext_clock_high_power;
  logic internal_osc_mode, watchdog_run, brownout_run, brownout_high_trip;
  logic [14:0] max_clock_khz;
  int n_errors = 0, total_checks = 0;
  cwp_row_t rows[7] = '{'{1, 16'h8001, 32'h155, 32'h0, 0},
    '{0, 16'h8001, 0, 32'h155, 0}, '{1, 16'h8006, 0, 0, 0},
    '{0, 16'h8006, 0, IDW, 0}, '{0, 16'h8007, 0, 32'h3FFF, 0},
    '{0, 16'h8008, 0, 32'h3FFF, 0}, '{0, 16'h8004, 0, 0, 1}};
  // Device and programmer
  cwp_top #(.PART_CODE(PART), .REV_CODE(5'h01)) uut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .por_n, .sleep_mode, .cpu_rd_addr, .cpu_rd_data, .self_wr_req,
    .self_wr_addr, .self_wr_data, .self_wr_done, .self_wr_blocked,
    .stack_overflow, .stack_underflow, .stack_fault_reset, .stack_wrap_mode,
    .ext_req, .ext_we, .ext_erase, .ext_addr, .ext_wdata, .ext_ack,
    .ext_rdata, .ext_clock_low_power, .ext_clock_medium_power,
    .ext_clock_high_power, .internal_osc_mode, .max_clock_khz,
    .watchdog_run, .brownout_run, .brownout_high_trip, .clock_out_enable);
  cwp_prog_model prog (.clk(pclk), .ext_ack, .ext_rdata, .ext_req, .ext_we,
    .ext_erase, .ext_addr, .ext_wdata);
  // Clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", n, x, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task hang;
    n_errors++;
    stop_test;
  endtask
  task clk_n(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // APB transfer, held until pready is sampled
  task apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rst;
    @(posedge pclk);
    presetn <= 0;
    clk_n(2);
    @(posedge pclk);
    presetn <= 1;
    clk_n(3);
  endtask
  // One-cycle CPU strobe
  task pulse(input logic s, input logic [9:0] a);
    @(posedge pclk);
    self_wr_req <= s;
    stack_overflow <= !s;
    self_wr_addr <= a;
    @(posedge pclk);
    self_wr_req <= 0;
    stack_overflow <= 0;
    #1;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    clk_n(3);
    chk("dec", {ext_clock_high_power, internal_osc_mode, watchdog_run,
      brownout_run, brownout_high_trip, stack_wrap_mode}, 6'b101100);
    chk("khz", max_clock_khz, EXT_HIGH_MAX_KHZ);
    foreach (rows[n]) begin
      apb(rows[n].w, rows[n].i, rows[n].d);
      chk("err", er, rows[n].e);
      if (!rows[n].w) chk("rd", rd, rows[n].x);
    end
    pulse(0, 0);
    chk("sfr", stack_fault_reset, 1);
    prog.xfer(1, 0, 16'h0010, 14'h1234);
    prog.xfer(0, 0, 16'h0010, 0);
    chk("xr", prog.rd, 14'h1234);
    prog.xfer(0, 0, 16'h8006, 0);
    chk("xid", prog.rd, IDW);
    prog.xfer(1, 0, 16'h8008, 14'h39FE);
    prog.xfer(1, 0, 16'h8007, 14'h3F64);
    rst;
    chk("dec", {ext_clock_high_power, internal_osc_mode, watchdog_run,
      brownout_run, brownout_high_trip, stack_wrap_mode}, 6'b010111);
    chk("khz", max_clock_khz, INT_OSC_MAX_KHZ);
    apb(0, 16'h8007, 0);
    chk("c1", rd, 32'h3F64);
    apb(0, 16'h8008, 0);
    chk("c2", rd, 32'h39FE);
    prog.xfer(0, 0, 16'h0010, 0);
    chk("xcp", prog.rd, 0);
    @(posedge pclk);
    cpu_rd_addr <= 10'h010;
    clk_n(2);
    chk("cpu", cpu_rd_data, 14'h1234);
    pulse(1, 10'h0FF);
    chk("blk", {self_wr_blocked, self_wr_done}, 2'b10);
    pulse(1, 10'h100);
    chk("ok", {self_wr_blocked, self_wr_done}, 2'b01);
    pulse(0, 0);
    chk("sfr", stack_fault_reset, 0);
    apb(0, IDX_STATUS, 0);
    chk("ovf", rd[STAT_OVF_BIT], 1);
    apb(1, IDX_STATUS, 1);
    apb(0, IDX_STATUS, 0);
    chk("ovc", rd[STAT_OVF_BIT], 0);
    prog.xfer(1, 0, 16'h8007, 14'h3FFF);
    rst;
    prog.xfer(0, 0, 16'h0010, 0);
    chk("cp1", prog.rd, 0);
    prog.xfer(0, 1, 16'h0000, 0);
    rst;
    prog.xfer(0, 0, 16'h0010, 0);
    chk("ers", prog.rd, ERASED_WORD);
    pulse(1, 10'h000);
    chk("wp0", {self_wr_blocked, self_wr_done}, 2'b01);
    prog.xfer(1, 0, 16'h8007, 14'h33F5);
    rst;
    chk("dec", {ext_clock_low_power, ext_clock_medium_power, clock_out_enable,
      watchdog_run, brownout_run}, 5'b10110);
    chk("khz", max_clock_khz, EXT_LOW_MAX_KHZ);
    @(posedge pclk);
    sleep_mode <= 1;
    apb(1, IDX_BOR_CTRL, 1);
    clk_n(2);
    chk("slp", {watchdog_run, brownout_run}, 2'b01);
    stop_test;
  end
endmodule
`default_nettype wire
